// file: rtl/acl_table_map.svh
// register indices, field positions, reset values and timing of the rule table access block
`ifndef ACL_TABLE_MAP_SVH
`define ACL_TABLE_MAP_SVH

// register indices; the bus byte address is four times the index
`define ACL_IDX_STAGE_FIRST 14'h0600
`define ACL_IDX_REMARK_LSB  14'h060b
`define ACL_IDX_SPARE       14'h060c
`define ACL_IDX_FWD_MAP     14'h060d
`define ACL_IDX_RULESET_HI  14'h060e
`define ACL_IDX_RULESET_LO  14'h060f
`define ACL_IDX_SEL_HIGH    14'h0610
`define ACL_IDX_SEL_LOW     14'h0611
`define ACL_IDX_CONTROL     14'h0612

// staging byte numbers that carry the action fields
`define ACL_BYTE_REMARK_MSB 4'ha
`define ACL_BYTE_REMARK_LSB 4'hb
`define ACL_BYTE_FWD_MAP    4'hd
`define ACL_BYTE_RULESET_HI 4'he
`define ACL_BYTE_RULESET_LO 4'hf

// field positions
`define ACL_REMARK_MSB_HI   1
`define ACL_REMARK_MSB_LO   0
`define ACL_REMARK_LSB_BIT  7
`define ACL_MAP_MODE_HI     6
`define ACL_MAP_MODE_LO     5
`define ACL_FWD_HI          6
`define ACL_FWD_LO          0
`define ACL_FWD_RSVD_BIT    4

// reset values
`define ACL_STAGE_RESET     8'h00
`define ACL_SEL_RESET       8'h00
`define ACL_INDEX_RESET     4'h0

// table access time
`define ACL_ACCESS_NS       10
`define ACL_CLK_PERIOD_NS   5

`endif

// file: rtl/acl_table_pkg.sv
// types shared by the rule table access block
package acl_table_pkg;

  // transfer sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_BUSY
  } acl_state_t;

  // control register layout
  typedef struct packed {
    logic       rsvd;      // reads zero
    logic       wr_done;   // write complete
    logic       rd_done;   // read complete
    logic       dir_write; // one write, zero read
    logic [3:0] index;     // table entry
  } acl_ctrl_t;

  // action fields as seen by the filter
  typedef struct packed {
    logic [2:0]  remark_priority;
    logic [1:0]  entry_map_mode;
    logic [6:0]  fwd_ports;
    logic [15:0] ruleset;
  } acl_action_t;

endpackage

// file: rtl/acl_table_indirect_access.sv
// indirect staging, byte select and control path to one port's rule table
// Operation
// - each port owns a table, reached indirectly
// - remark priority upper bits in byte a
// - remark priority lsb bit 7, joined
// - seven bit forward map, bit0 port1
// - forward map bit 4 reserved, unused
// - low select write launches; only enabled bytes
// - high select bits map reversed to 7..0
// - low select bits map reversed to 15..8
// - write done bit 6, zero pending, resets one
// - read done bit 5, poll before use
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acl_table_map.svh"

module acl_table_indirect_access #(
  parameter int ENTRIES = 16, // table entries per port
  parameter int BYTES   = 16  // staging bytes per entry
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [15:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output acl_table_pkg::acl_action_t     staged_action,
  output logic                           busy
);

  // table access time in cycles, rounded up, at least one
  // the counter runs from ACC_LOAD down to zero, one commit at zero
  localparam int ACC_RAW = (`ACL_ACCESS_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS;
  localparam int ACC_CYC = (ACC_RAW < 1) ? 1 : ACC_RAW;
  localparam logic [3:0] ACC_LOAD = 4'(ACC_CYC - 1);

  // true when a word index names a register of this block
  function automatic logic is_mapped(input logic [13:0] idx);
    is_mapped = (idx >= `ACL_IDX_STAGE_FIRST) && (idx <= `ACL_IDX_CONTROL);
  endfunction

  // staging byte k is chosen by select bit 15-k
  function automatic logic byte_chosen(input logic [15:0] sel, input int k);
    byte_chosen = sel[15 - k];
  endfunction

  // per port table, one instance per port
  logic [7:0] table_q [ENTRIES][BYTES];

  // register state
  logic [7:0]                 stage_q [BYTES]; // staging bytes
  logic [7:0]                 stage_d [BYTES];
  logic [7:0]                 sel_hi_q;        // select bits 15:8
  logic [7:0]                 sel_hi_d;
  logic [7:0]                 sel_lo_q;        // select bits 7:0
  logic [7:0]                 sel_lo_d;
  acl_table_pkg::acl_ctrl_t   ctrl_q;          // control and status
  acl_table_pkg::acl_ctrl_t   ctrl_d;
  acl_table_pkg::acl_state_t  state_q;         // sequencer state
  acl_table_pkg::acl_state_t  state_d;
  logic [3:0]                 cnt_q;           // access cycles left
  logic [3:0]                 cnt_d;
  logic [31:0]                rdata_q;         // read data
  logic [31:0]                rdata_d;
  logic                       err_q;           // error answer
  logic                       err_d;
  acl_table_pkg::acl_action_t act_q;           // staged action fields
  acl_table_pkg::acl_action_t act_d;

  // bus decode
  logic [13:0] widx;      // word index
  logic        addr_ok;   // mapped, word aligned
  logic        wr_acc;    // write taken this edge
  logic        launch;    // transfer start
  logic        commit;    // transfer finishes this edge
  logic [15:0] sel_all;   // full select word
  logic        tbl_we;    // table write strobe

  // word index; misaligned or unmapped words answer with an error
  assign widx    = paddr[15:2];
  assign addr_ok = is_mapped(widx) && (paddr[1:0] == 2'b00);
  assign wr_acc  = psel && penable && pwrite && addr_ok && pstrb[0];
  // launch only from idle; a low select write while busy is dropped
  assign launch  = wr_acc && (widx == `ACL_IDX_SEL_LOW) && (state_q == acl_table_pkg::ST_IDLE);
  assign commit  = (state_q == acl_table_pkg::ST_BUSY) && (cnt_q == 4'h0);
  assign sel_all = {sel_hi_q, sel_lo_q};
  assign tbl_we  = commit && ctrl_q.dir_write;

  // answer in the access phase, no wait states
  assign pready  = psel && penable;
  assign pslverr = err_q;
  assign prdata  = rdata_q;
  assign busy    = (state_q == acl_table_pkg::ST_BUSY);
  assign staged_action = act_q;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      acl_table_pkg::ST_IDLE: begin
        if (launch) begin
          state_d = acl_table_pkg::ST_BUSY;
          cnt_d   = ACC_LOAD;
        end
      end
      acl_table_pkg::ST_BUSY: begin
        // count down, finish on the zero cycle
        if (cnt_q == 4'h0) begin
          state_d = acl_table_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = acl_table_pkg::ST_IDLE;
        cnt_d   = 4'h0;
      end
    endcase
  end

  // select and control next values
  always_comb begin
    sel_hi_d = sel_hi_q;
    sel_lo_d = sel_lo_q;
    ctrl_d   = ctrl_q;
    // select, direction and index are frozen while a transfer runs; done bits still set at commit
    if (wr_acc && !busy) begin
      if (widx == `ACL_IDX_SEL_HIGH) begin
        sel_hi_d = pwdata[7:0];
      end
      if (widx == `ACL_IDX_SEL_LOW) begin
        sel_lo_d = pwdata[7:0];
      end
      if (widx == `ACL_IDX_CONTROL) begin
        ctrl_d.dir_write = pwdata[4];   // direction bit
        ctrl_d.index     = pwdata[3:0]; // entry index
      end
    end
    // status low while pending, high once done
    if (launch) begin
      if (ctrl_q.dir_write) begin
        ctrl_d.wr_done = 1'b0;
      end else begin
        ctrl_d.rd_done = 1'b0;
      end
    end
    if (commit) begin
      ctrl_d.wr_done = 1'b1;
      ctrl_d.rd_done = 1'b1;
    end
    // bit 7 is reserved and reads zero
    ctrl_d.rsvd = 1'b0;
  end

  // staging next values; a read load beats a bus write to the same byte
  // staging bytes stay writable while a transfer runs
  always_comb begin
    for (int k = 0; k < BYTES; k++) begin
      stage_d[k] = stage_q[k];
      if (wr_acc && (widx == (`ACL_IDX_STAGE_FIRST + 14'(k)))) begin
        stage_d[k] = pwdata[7:0];
      end
      // only enabled bytes load, others keep their value
      if (commit && !ctrl_q.dir_write && byte_chosen(sel_all, k)) begin
        stage_d[k] = table_q[ctrl_q.index][k];
      end
    end
  end

  // read data and error for the access phase
  // registered at the setup edge, shown during the access phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (psel && !penable) begin
      if (!addr_ok) begin
        err_d = 1'b1;
      end else if (!pwrite) begin
        if (widx == `ACL_IDX_CONTROL) begin
          rdata_d = {24'h00_0000, ctrl_q};
        end else if (widx == `ACL_IDX_SEL_HIGH) begin
          rdata_d = {24'h00_0000, sel_hi_q};
        end else if (widx == `ACL_IDX_SEL_LOW) begin
          rdata_d = {24'h00_0000, sel_lo_q};
        end else begin
          // staging and spare bytes share one decode
          rdata_d = {24'h00_0000, stage_q[widx[3:0]]};
        end
      end
    end
  end

  // action fields decoded from the staging bytes
  always_comb begin
    act_d.remark_priority = {
      stage_q[`ACL_BYTE_REMARK_MSB][`ACL_REMARK_MSB_HI:`ACL_REMARK_MSB_LO],
      stage_q[`ACL_BYTE_REMARK_LSB][`ACL_REMARK_LSB_BIT]};
    act_d.entry_map_mode =
      stage_q[`ACL_BYTE_REMARK_LSB][`ACL_MAP_MODE_HI:`ACL_MAP_MODE_LO];
    act_d.fwd_ports = stage_q[`ACL_BYTE_FWD_MAP][`ACL_FWD_HI:`ACL_FWD_LO];
    act_d.fwd_ports[`ACL_FWD_RSVD_BIT] = 1'b0;
    act_d.ruleset = {stage_q[`ACL_BYTE_RULESET_HI], stage_q[`ACL_BYTE_RULESET_LO]};
  end

  // register stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= acl_table_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      sel_hi_q <= `ACL_SEL_RESET;
      sel_lo_q <= `ACL_SEL_RESET;
      ctrl_q  <= '{rsvd: 1'b0, wr_done: 1'b1, rd_done: 1'b1, dir_write: 1'b0,
                   index: `ACL_INDEX_RESET};
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
      act_q   <= '0;
      for (int k = 0; k < BYTES; k++) begin
        stage_q[k] <= `ACL_STAGE_RESET;
      end
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sel_hi_q <= sel_hi_d;
      sel_lo_q <= sel_lo_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
      act_q   <= act_d;
      for (int k = 0; k < BYTES; k++) begin
        stage_q[k] <= stage_d[k];
      end
    end
  end

  // table store: only enabled staging bytes are written
  // table contents have no reset; software fills them
  always_ff @(posedge sys_clk) begin
    for (int k = 0; k < BYTES; k++) begin
      if (tbl_we && byte_chosen(sel_all, k)) begin
        table_q[ctrl_q.index][k] <= stage_q[k];
      end
    end
  end

  // transfer lasts exactly the access time
  a_busy_span: assert property (@(posedge sys_clk) disable iff (reset)
    launch |=> busy [*2] ##1 !busy)
    else $error("transfer length wrong");

  // write pending flag low until completion
  a_write_pending: assert property (@(posedge sys_clk) disable iff (reset)
    (launch && ctrl_q.dir_write) |=> !ctrl_q.wr_done [*2] ##1 ctrl_q.wr_done)
    else $error("write status wrong");

  // read pending flag low until completion
  a_read_pending: assert property (@(posedge sys_clk) disable iff (reset)
    (launch && !ctrl_q.dir_write) |=> !ctrl_q.rd_done [*2] ##1 ctrl_q.rd_done)
    else $error("read status wrong");

  // status reads one after reset
  a_status_reset: assert property (@(posedge sys_clk)
    $past(reset) |-> (ctrl_q.wr_done && ctrl_q.rd_done))
    else $error("status not one after reset");

  // enabled byte loaded from the entry on read completion
  a_read_load: assert property (@(posedge sys_clk) disable iff (reset)
    (commit && !ctrl_q.dir_write && sel_lo_q[0])
      |=> stage_q[15] == $past(table_q[ctrl_q.index][15]))
    else $error("enabled byte not loaded");

  // disabled byte kept on read completion
  a_read_keep: assert property (@(posedge sys_clk) disable iff (reset)
    (commit && !ctrl_q.dir_write && !sel_lo_q[7] && !wr_acc)
      |=> $stable(stage_q[8]))
    else $error("disabled byte changed");

  // enabled byte stored on write completion
  a_write_store: assert property (@(posedge sys_clk) disable iff (reset)
    (commit && ctrl_q.dir_write && sel_hi_q[7])
      |=> table_q[$past(ctrl_q.index)][0] == $past(stage_q[0]))
    else $error("enabled byte not stored");

  // remark priority joins both bytes
  a_remark_join: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 act_q.remark_priority ==
      {$past(stage_q[`ACL_BYTE_REMARK_MSB][`ACL_REMARK_MSB_HI:`ACL_REMARK_MSB_LO]),
       $past(stage_q[`ACL_BYTE_REMARK_LSB][`ACL_REMARK_LSB_BIT])})
    else $error("remark priority wrong");

  // reserved forward bit never set
  a_fwd_rsvd: assert property (@(posedge sys_clk) disable iff (reset)
    !act_q.fwd_ports[`ACL_FWD_RSVD_BIT])
    else $error("reserved forward bit set");

  // unmapped address answers with error
  a_unmapped_err: assert property (@(posedge sys_clk) disable iff (reset)
    (psel && !penable && !addr_ok) |=> pslverr)
    else $error("no error on unmapped address");

  // mapped address answers without error
  a_mapped_ok: assert property (@(posedge sys_clk) disable iff (reset)
    (psel && !penable && addr_ok) |=> !pslverr)
    else $error("error on mapped address");

  // control read shows the status held at setup
  a_ctrl_read: assert property (@(posedge sys_clk) disable iff (reset)
    (psel && !penable && addr_ok && !pwrite && (widx == `ACL_IDX_CONTROL))
      |=> prdata == {24'h00_0000, $past(ctrl_q)})
    else $error("control read data wrong");

  // high select takes the written byte when idle
  a_sel_high_write: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_acc && !busy && (widx == `ACL_IDX_SEL_HIGH)) |=> sel_hi_q == $past(pwdata[7:0]))
    else $error("high select not written");

  // only the write done bit drops when a write transfer launches
  a_launch_status: assert property (@(posedge sys_clk) disable iff (reset)
    (launch && ctrl_q.dir_write) |=> (!ctrl_q.wr_done && ctrl_q.rd_done))
    else $error("write launch status wrong");

  // both status bits return to one at completion
  a_done_restore: assert property (@(posedge sys_clk) disable iff (reset)
    commit |=> (ctrl_q.wr_done && ctrl_q.rd_done))
    else $error("status not restored");

  // no status bit is low while idle
  a_idle_status: assert property (@(posedge sys_clk) disable iff (reset)
    !busy |-> (ctrl_q.wr_done && ctrl_q.rd_done))
    else $error("status low while idle");

  // select, direction and index frozen while a transfer runs
  a_select_frozen: assert property (@(posedge sys_clk) disable iff (reset)
    busy |=> ($stable(sel_hi_q) && $stable(sel_lo_q) && $stable(ctrl_q.index)
      && $stable(ctrl_q.dir_write)))
    else $error("select changed while busy");

endmodule
`default_nettype wire

// file: tb/acl_table_indirect_access_tb_top.sv
// self-checking bench for the rule table staging, byte select and control path
`timescale 1ns/1ps
`default_nettype none
`include "acl_table_map.svh"

module acl_table_indirect_access_tb_top;
  logic                       sys_clk = 1'b0;  // 200 MHz clock
  logic                       reset   = 1'b1;  // sync reset, active high
  logic                       psel    = 1'b0;  // apb select
  logic                       penable = 1'b0;  // apb access phase
  logic                       pwrite  = 1'b0;  // apb direction
  logic [15:0]                paddr   = 16'h0000;
  logic [31:0]                pwdata  = 32'h0000_0000;
  logic [31:0]                prdata;          // read data
  logic                       pready;          // transfer answer
  logic                       pslverr;         // transfer error
  logic                       busy;            // table transfer running
  acl_table_pkg::acl_action_t staged_action;   // action fields seen by the filter
  int                         miscompares = 0; // mismatches seen
  int                         tests_run   = 0; // comparisons made
  logic [31:0]                rd;              // last read data
  logic                       err;             // last error answer

  // clock, half period 2.5 ns
  always #2.5 sys_clk = ~sys_clk;

  acl_table_indirect_access uut (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pstrb         (4'hf),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .staged_action (staged_action),
    .busy          (busy)
  );

  // counts, verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // value compare, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr_en, input logic [13:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // register write, no error expected
  task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
    chk({31'h0, err}, 32'h0000_0000);
  endtask

  // register read against an expected byte
  task automatic rdc(input logic [13:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask

  // launch a table transfer and poll its status bit
  task automatic op(input logic [7:0] ctrl, input logic [7:0] selh, input logic [7:0] sell,
                    input int bit_pos);
    int n;
    n = 0;
    wr(`ACL_IDX_CONTROL, ctrl);
    wr(`ACL_IDX_SEL_HIGH, selh);
    wr(`ACL_IDX_SEL_LOW, sell);
    #1;
    chk({31'h0, busy}, 32'h0000_0001);
    apb(1'b0, `ACL_IDX_CONTROL, 8'h00);
    chk({31'h0, rd[bit_pos]}, 32'h0000_0000);
    while (rd[bit_pos] !== 1'b1 && n < 20) begin
      apb(1'b0, `ACL_IDX_CONTROL, 8'h00);
      n++;
    end
    if (rd[bit_pos] !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(`ACL_IDX_CONTROL, 8'h60);
    rdc(`ACL_IDX_SEL_HIGH, 8'h00);
    rdc(`ACL_IDX_SEL_LOW, 8'h00);
    rdc(`ACL_IDX_FWD_MAP, 8'h00);
    // zero entry 3 bytes a..f, then stage the action fields
    op(8'h13, 8'h00, 8'h3f, 6);
    wr(`ACL_IDX_STAGE_FIRST + 14'd10, 8'h03);
    wr(`ACL_IDX_REMARK_LSB, 8'he0);
    wr(`ACL_IDX_FWD_MAP, 8'h7f);
    wr(`ACL_IDX_RULESET_HI, 8'ha5);
    wr(`ACL_IDX_RULESET_LO, 8'h5a);
    repeat (2) @(posedge sys_clk);
    chk({4'h0, staged_action}, {4'h0, 3'h7, 2'h3, 7'h6f, 16'ha55a});
    // write bytes b..f only, byte a stays zero in the table
    op(8'h13, 8'h00, 8'h1f, 6);
    rdc(`ACL_IDX_CONTROL, 8'h73);
    for (int k = 10; k < 16; k++) begin
      wr(`ACL_IDX_STAGE_FIRST + 14'(k), 8'h00);
    end
    // read back bytes a and e only
    op(8'h03, 8'h00, 8'h22, 5);
    rdc(`ACL_IDX_STAGE_FIRST + 14'd10, 8'h00);
    rdc(`ACL_IDX_RULESET_HI, 8'ha5);
    rdc(`ACL_IDX_RULESET_LO, 8'h00);
    rdc(`ACL_IDX_FWD_MAP, 8'h00);
    // then bytes b, d and f
    op(8'h03, 8'h00, 8'h15, 5);
    rdc(`ACL_IDX_RULESET_LO, 8'h5a);
    rdc(`ACL_IDX_FWD_MAP, 8'h7f);
    rdc(`ACL_IDX_REMARK_LSB, 8'he0);
    rdc(`ACL_IDX_CONTROL, 8'h63);
    // upper select bits, reversed onto bytes 7..0, entry 5
    wr(`ACL_IDX_STAGE_FIRST + 14'd7, 8'h3c);
    wr(`ACL_IDX_STAGE_FIRST, 8'h05);
    op(8'h15, 8'h81, 8'h00, 6);
    wr(`ACL_IDX_STAGE_FIRST + 14'd7, 8'h00);
    wr(`ACL_IDX_STAGE_FIRST, 8'h00);
    op(8'h05, 8'h01, 8'h00, 5);
    rdc(`ACL_IDX_STAGE_FIRST + 14'd7, 8'h3c);
    rdc(`ACL_IDX_STAGE_FIRST, 8'h00);
    op(8'h05, 8'h80, 8'h00, 5);
    rdc(`ACL_IDX_STAGE_FIRST, 8'h05);
    // unmapped index answers with an error
    apb(1'b0, 14'h0613, 8'h00);
    chk({31'h0, err}, 32'h0000_0001);
    test_done();
  end
endmodule
`default_nettype wire
